// file: hw/flash_burst_config.sv
// Purpose: burst configuration register and the synchronous burst read it steers
// Assumes: array data is readable in the cycle its address is shown
// Notes: falling-edge output is left to the pad stage via active_edge_rise
`timescale 1ns/1ps
`include "flash_burst_map.svh"
module flash_burst_config (
	input wire logic clk,
	input wire logic rst,
	input wire logic reduced_handshake,
	input wire logic wr_en,
	input wire logic [`ADDR_W-1:0] wr_addr,
	input wire logic [`DATA_W-1:0] wr_data,
	input wire logic array_busy,
	input wire logic chip_enable_n,
	input wire logic address_valid_strobe_n,
	input wire logic [`ADDR_W-1:0] start_addr,
	input wire logic burst_hold,
	output logic [`ADDR_W-1:0] array_addr,
	input wire logic [`DATA_W-1:0] array_data,
	output logic [`DATA_W-1:0] burst_data,
	output logic rdy_o,
	output logic rdy_oe,
	output logic sync_mode,
	output logic active_edge_rise,
	output logic cfg_loaded
);
	logic [7:0] cfg_q;
	logic loaded_q;
	flash_burst_pkg::cmd_state_t cmd_q;
	flash_burst_pkg::burst_state_t st_q;
	logic [3:0] lat_q;
	logic [`ADDR_W-1:0] ptr_q;
	logic [`ADDR_W-1:0] ptr_next;
	logic [`DATA_W-1:0] dout_q;
	logic dvalid_q;
	logic [2:0] wait_code;
	flash_burst_pkg::wrap_t wrap;
	logic sync_ok;
	logic start;
	logic cfg_hit;
	logic [3:0] lat_total;
	logic fetch;
	logic fetch_ready;
	logic [`ADDR_W-1:0] fetch_addr;
	logic pop_ok;
	logic pop;
	logic fifo_valid;
	logic [`DATA_W-1:0] fifo_data;
	logic rdy_with_data;
	logic [3:0] since_q;
	logic [3:0] exp_q;

	// initial access cycles for a wait code; reserved codes run as the slowest setting
	function automatic logic [3:0] wait_cycles(input logic [2:0] code);
		if (code > `WAIT_CODE_MAX) begin
			return `WAIT_RSVD;
		end
		return `WAIT_BASE + 4'(code);
	endfunction : wait_cycles

	// boundary start words cost extra cycles only with reduced handshaking
	function automatic logic [3:0] first_latency(input logic [2:0] code, input logic red,
		input logic [`ADDR_W-1:0] a);
		logic edge_word;
		edge_word = a[`EDGE_WORD_HI:`EDGE_WORD_LO] == `EDGE_WORD;
		if (red && edge_word) begin
			return wait_cycles(code) + `WAIT_EXTRA;
		end
		return wait_cycles(code);
	endfunction : first_latency

	// field decode of the live configuration
	assign wait_code = cfg_q[`CFG_WAIT_HI:`CFG_WAIT_LO];
	assign wrap = flash_burst_pkg::wrap_t'(cfg_q[`CFG_WRAP_HI:`CFG_WRAP_LO]);
	assign sync_ok = loaded_q && !cfg_q[`CFG_ASYNC_BIT];
	assign sync_mode = sync_ok;
	assign active_edge_rise = cfg_q[`CFG_EDGE_BIT];
	assign cfg_loaded = loaded_q;
	// a two-cycle wait leaves no room for an early ready
	assign rdy_with_data = cfg_q[`CFG_RDY_BIT] || wait_code == `WAIT_CODE_MIN;

	// third write of the sequence
	assign cfg_hit = wr_en && cmd_q == flash_burst_pkg::CMD_UNL2
		&& wr_addr[`CMD_ADDR_HI:0] == `CMD_ADDR_A
		&& wr_data[7:0] == `CMD_DATA_CFG;

	// command sequence tracker; any stray write falls back to idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_q <= flash_burst_pkg::CMD_IDLE;
		end else if (wr_en) begin
			unique case (cmd_q)
				flash_burst_pkg::CMD_IDLE: begin
					if (wr_addr[`CMD_ADDR_HI:0] == `CMD_ADDR_A && wr_data[7:0] == `CMD_DATA_A) begin
						cmd_q <= flash_burst_pkg::CMD_UNL1;
					end
				end
				flash_burst_pkg::CMD_UNL1: begin
					if (wr_addr[`CMD_ADDR_HI:0] == `CMD_ADDR_B && wr_data[7:0] == `CMD_DATA_B) begin
						cmd_q <= flash_burst_pkg::CMD_UNL2;
					end else begin
						cmd_q <= flash_burst_pkg::CMD_IDLE;
					end
				end
				flash_burst_pkg::CMD_UNL2: begin
					cmd_q <= flash_burst_pkg::CMD_IDLE;
				end
				default: begin
					cmd_q <= flash_burst_pkg::CMD_IDLE;
				end
			endcase
		end
	end

	// configuration register; a load during a busy array operation is dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= `CFG_RESET;
			loaded_q <= 1'b0;
		end else if (cfg_hit && !array_busy) begin
			cfg_q <= wr_addr[`CFG_ADDR_HI:`CFG_ADDR_LO];
			loaded_q <= 1'b1;
		end
	end

	// a low strobe with the chip selected opens a burst once burst mode is loaded
	assign start = !address_valid_strobe_n && !chip_enable_n && sync_ok;
	assign lat_total = first_latency(wait_code, reduced_handshake, start_addr);

	// burst engine state and initial wait count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= flash_burst_pkg::BST_IDLE;
			lat_q <= '0;
		end else if (chip_enable_n || !sync_ok) begin
			st_q <= flash_burst_pkg::BST_IDLE;
			lat_q <= '0;
		end else if (start) begin
			st_q <= flash_burst_pkg::BST_WAIT;
			lat_q <= lat_total - `WAIT_BASE;
		end else begin
			unique case (st_q)
				flash_burst_pkg::BST_IDLE: begin
					st_q <= flash_burst_pkg::BST_IDLE;
				end
				flash_burst_pkg::BST_WAIT: begin
					if (lat_q == '0) begin
						st_q <= flash_burst_pkg::BST_RUN;
					end else begin
						lat_q <= lat_q - 4'h1;
					end
				end
				flash_burst_pkg::BST_RUN: begin
					st_q <= flash_burst_pkg::BST_RUN;
				end
				default: begin
					st_q <= flash_burst_pkg::BST_IDLE;
				end
			endcase
		end
	end

	// fetch starts in the strobe cycle so a two-cycle wait still has data
	assign fetch_addr = start ? start_addr : ptr_q;
	assign fetch = start || st_q != flash_burst_pkg::BST_IDLE;
	assign array_addr = fetch_addr;

	burst_addr_step u_step (
		.addr(fetch_addr),
		.wrap(wrap),
		.next(ptr_next)
	);

	// address pointer walks whenever a fetch finds the buffer ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_q <= '0;
		end else if (fetch && fetch_ready) begin
			ptr_q <= ptr_next;
		end else if (start) begin
			ptr_q <= start_addr;
		end
	end

	// buffer absorbs fetch while the host holds the burst
	burst_fifo #(
		.WIDTH(`DATA_W),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.flush(start || chip_enable_n),
		.in_valid(fetch && !chip_enable_n),
		.in_ready(fetch_ready),
		.in_data(array_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// words leave once the initial wait has run out
	assign pop_ok = st_q == flash_burst_pkg::BST_RUN
		|| (st_q == flash_burst_pkg::BST_WAIT && lat_q == '0);
	assign pop = pop_ok && fifo_valid && !burst_hold && !start && !chip_enable_n;

	// output word register; a held cycle shows no valid data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout_q <= '0;
			dvalid_q <= 1'b0;
		end else begin
			dvalid_q <= pop;
			if (pop) dout_q <= fifo_data;
		end
	end
	assign burst_data = dout_q;

	// ready pin: driven in burst mode, released like open drain otherwise
	always_comb begin
		rdy_oe = sync_ok;
		rdy_o = rdy_with_data ? dvalid_q : pop;
		if (!sync_ok) rdy_o = 1'b0;
	end

	// helper for latency checks: cycles since the strobe and the expected total
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_q <= '0;
			exp_q <= '0;
		end else if (start) begin
			since_q <= 4'h1;
			exp_q <= lat_total;
		end else if (since_q != 4'hF) begin
			since_q <= since_q + 4'h1;
		end
	end

	// named steps: the configuration load and the first burst word
	sequence s_cfg_write;
		cfg_hit && !array_busy;
	endsequence

	sequence s_first_word;
		st_q == flash_burst_pkg::BST_WAIT && lat_q == '0 && !chip_enable_n;
	endsequence

	property p_refuse_unloaded;
		@(posedge clk) disable iff (rst)
		st_q != flash_burst_pkg::BST_IDLE |-> loaded_q;
	endproperty
	a_refuse_unloaded: assert property (p_refuse_unloaded) else $error("burst without configuration");

	property p_load_value;
		@(posedge clk) disable iff (rst)
		s_cfg_write |=> cfg_q == $past(wr_addr[`CFG_ADDR_HI:`CFG_ADDR_LO]) && loaded_q;
	endproperty
	a_load_value: assert property (p_load_value) else $error("configuration not latched");

	property p_busy_frozen;
		@(posedge clk) disable iff (rst)
		array_busy |=> $stable(cfg_q);
	endproperty
	a_busy_frozen: assert property (p_busy_frozen) else $error("configuration changed while busy");

	property p_async_no_burst;
		@(posedge clk) disable iff (rst)
		cfg_q[`CFG_ASYNC_BIT] |-> !sync_mode && !rdy_oe && !start;
	endproperty
	a_async_no_burst: assert property (p_async_no_burst) else $error("burst in asynchronous mode");

	property p_first_latency;
		@(posedge clk) disable iff (rst)
		s_first_word |-> since_q == exp_q - 4'h1;
	endproperty
	a_first_latency: assert property (p_first_latency) else $error("initial access count wrong");

	property p_wait_two_with_data;
		@(posedge clk) disable iff (rst)
		sync_ok && wait_code == `WAIT_CODE_MIN |-> rdy_o == dvalid_q;
	endproperty
	a_wait_two_with_data: assert property (p_wait_two_with_data) else $error("early ready at wait two");

	property p_early_ready;
		@(posedge clk) disable iff (rst)
		sync_ok && !rdy_with_data && rdy_o ##1 !start |-> dvalid_q;
	endproperty
	a_early_ready: assert property (p_early_ready) else $error("early ready not followed by data");

	property p_group_kept;
		@(posedge clk) disable iff (rst)
		wrap != flash_burst_pkg::WRAP_CONT |->
			ptr_next[`ADDR_W-1:`GROUP_BITS] == fetch_addr[`ADDR_W-1:`GROUP_BITS];
	endproperty
	a_group_kept: assert property (p_group_kept) else $error("wrap crossed a 64-word block");

	// last word of an 8-word group, taken by the buffer
	sequence s_group_end;
		wrap == flash_burst_pkg::WRAP_8 && fetch_addr[2:0] == 3'h7 && fetch && fetch_ready;
	endsequence

	property p_wrap_return;
		@(posedge clk) disable iff (rst)
		s_group_end |=> ptr_q[2:0] == 3'h0 && ptr_q[`ADDR_W-1:3] == $past(fetch_addr[`ADDR_W-1:3]);
	endproperty
	a_wrap_return: assert property (p_wrap_return) else $error("wrap did not return to group start");

	property p_cont_rollover;
		@(posedge clk) disable iff (rst)
		wrap == flash_burst_pkg::WRAP_CONT && fetch && fetch_ready && fetch_addr == '1 |=> ptr_q == '0;
	endproperty
	a_cont_rollover: assert property (p_cont_rollover) else $error("continuous burst did not roll over");

	property p_mode_follows_load;
		@(posedge clk) disable iff (rst)
		s_cfg_write |=> sync_mode == !$past(wr_addr[`CFG_ADDR_HI]);
	endproperty
	a_mode_follows_load: assert property (p_mode_follows_load) else $error("read mode not taken from bit 19");

	// reserved wait codes run as the slowest setting
	property p_reserved_slowest;
		@(posedge clk) disable iff (rst)
		start && !reduced_handshake && wait_code > `WAIT_CODE_MAX |=> lat_q == `WAIT_RSVD - `WAIT_BASE;
	endproperty
	a_reserved_slowest: assert property (p_reserved_slowest) else $error("reserved wait code not slowest");

endmodule : flash_burst_config

// file: pkg/flash_burst_map.svh
// Purpose: offsets, field positions, reset values and counts of the burst configuration block
// Assumes: included by bare name wherever a design file needs a constant
// Notes: definitions only
`ifndef FLASH_BURST_MAP_SVH
`define FLASH_BURST_MAP_SVH
// configuration value as latched from address bits 19..12
`define CFG_ADDR_HI 19
`define CFG_ADDR_LO 12
`define CFG_RESET 8'hE5
`define CFG_ASYNC_BIT 7
`define CFG_RDY_BIT 6
`define CFG_EDGE_BIT 5
`define CFG_WRAP_HI 4
`define CFG_WRAP_LO 3
`define CFG_WAIT_HI 2
`define CFG_WAIT_LO 0
// command sequence
`define CMD_ADDR_HI 11
`define CMD_ADDR_A 12'h555
`define CMD_ADDR_B 12'h2AA
`define CMD_DATA_A 8'hAA
`define CMD_DATA_B 8'h55
`define CMD_DATA_CFG 8'hC0
// initial access counts, in clock cycles
`define WAIT_BASE 4'h2
`define WAIT_RSVD 4'h7
`define WAIT_EXTRA 4'h2
`define WAIT_CODE_MIN 3'h0
`define WAIT_CODE_MAX 3'h5
// boundary start words 3Eh and 3Fh share bits 5..1
`define EDGE_WORD_HI 5
`define EDGE_WORD_LO 1
`define EDGE_WORD 5'h1F
`define GROUP_BITS 6
// widths and depths
`define ADDR_W 22
`define DATA_W 16
`define FIFO_DEPTH 16
`endif

// file: pkg/flash_burst_pkg.sv
// Purpose: types shared by the burst configuration block
// Assumes: nothing
// Notes: constants live in flash_burst_map.svh
package flash_burst_pkg;
	// burst wrap kinds as coded in the configuration value
	typedef enum logic [1:0] {
		WRAP_CONT = 2'h0,
		WRAP_8 = 2'h1,
		WRAP_16 = 2'h2,
		WRAP_32 = 2'h3
	} wrap_t;
	// command sequence tracker, one-hot
	typedef enum logic [2:0] {
		CMD_IDLE = 3'h1,
		CMD_UNL1 = 3'h2,
		CMD_UNL2 = 3'h4
	} cmd_state_t;
	// burst engine, one-hot
	typedef enum logic [2:0] {
		BST_IDLE = 3'h1,
		BST_WAIT = 3'h2,
		BST_RUN = 3'h4
	} burst_state_t;
endpackage : flash_burst_pkg

// file: hw/burst_fifo.sv
// Purpose: word buffer between array fetch and burst output
// Assumes: single clock, flush empties it in one cycle
// Notes: a push in the flush cycle is kept as the only word
`timescale 1ns/1ps
module burst_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// honest full and empty from the word count; a flush frees room so a restart is never refused
	assign in_ready = flush || cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready && !flush;

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[flush ? rd_q : wr_q] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= push ? rd_q + 1'b1 : rd_q;
			cnt_q <= push ? (AW+1)'(1) : '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : burst_fifo

// file: hw/burst_addr_step.sv
// Purpose: next burst word address for the selected wrap kind
// Assumes: wrap groups are aligned to their own size
// Notes: continuous mode rolls over from the top word to zero
`timescale 1ns/1ps
`include "flash_burst_map.svh"
module burst_addr_step (
	input wire logic [`ADDR_W-1:0] addr,
	input wire flash_burst_pkg::wrap_t wrap,
	output logic [`ADDR_W-1:0] next
);
	logic [`ADDR_W-1:0] mask;
	logic [`ADDR_W-1:0] inc;

	// bits that may move; groups of 8, 16, 32 never leave their 64-word block
	always_comb begin
		unique case (wrap)
			flash_burst_pkg::WRAP_8: mask = `ADDR_W'(8'h07);
			flash_burst_pkg::WRAP_16: mask = `ADDR_W'(8'h0F);
			flash_burst_pkg::WRAP_32: mask = `ADDR_W'(8'h1F);
			flash_burst_pkg::WRAP_CONT: mask = '1;
		endcase
	end
	assign inc = addr + `ADDR_W'(1);
	assign next = (addr & ~mask) | (inc & mask);
endmodule : burst_addr_step

// file: verification/host_model.sv
// Purpose: host controller model that loads the burst register and starts bursts
// Assumes: the device samples every request on the rising clock edge
// Notes: released lines show the inverse of their last value, never a stale copy
`timescale 1ns/1ps
`include "flash_burst_map.svh"
module host_model (
	input wire logic clk,
	output logic wr_en,
	output logic [`ADDR_W-1:0] wr_addr,
	output logic [`DATA_W-1:0] wr_data,
	output logic chip_enable_n,
	output logic address_valid_strobe_n,
	output logic [`ADDR_W-1:0] start_addr,
	output logic burst_hold
);
	// idle bus at time zero, chip deselected
	initial begin
		wr_en = 1'b0;
		wr_addr = 22'h000000;
		wr_data = 16'h0000;
		chip_enable_n = 1'b1;
		address_valid_strobe_n = 1'b1;
		start_addr = 22'h000000;
		burst_hold = 1'b0;
	end
	// one write cycle; back to back calls keep wr_en high
	task automatic write_cycle(input logic [21:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
	endtask : write_cycle
	// released after the last write was taken
	task automatic write_release();
		@(posedge clk);
		wr_en <= 1'b0;
		wr_addr <= ~wr_addr;
		wr_data <= ~wr_data;
	endtask : write_release
	// full load; the wait code always travels so the setting is known
	task automatic load(input logic [7:0] v);
		write_cycle({10'h000, `CMD_ADDR_A}, {8'h00, `CMD_DATA_A});
		write_cycle({10'h000, `CMD_ADDR_B}, {8'h00, `CMD_DATA_B});
		write_cycle({2'h0, v, `CMD_ADDR_A}, {8'h00, `CMD_DATA_CFG});
		write_release();
	endtask : load
	// strobe for one cycle, chip enabled, optional stall from the start
	task automatic strobe(input logic [21:0] a, input logic h);
		@(posedge clk);
		chip_enable_n <= 1'b0;
		address_valid_strobe_n <= 1'b0;
		start_addr <= a;
		burst_hold <= h;
		@(posedge clk);
		address_valid_strobe_n <= 1'b1;
		start_addr <= ~a;
	endtask : strobe
	// deselect ends the burst and flushes the buffer
	task automatic end_burst();
		@(posedge clk);
		chip_enable_n <= 1'b1;
		burst_hold <= 1'b0;
	endtask : end_burst
	// stall ends on the next edge, burst stays selected
	task automatic release_hold();
		@(posedge clk);
		burst_hold <= 1'b0;
	endtask : release_hold
endmodule : host_model

// file: verification/testbench.sv
// Purpose: self-checking bench for the burst configuration register and burst read
// Assumes: array answers in the same cycle, ready sits with data when bit 18 is set
// Notes: latency counted from the edge that drives the strobe low, sampled 1 ns after each edge
`timescale 1ns/1ps
`include "flash_burst_map.svh"
`define check_eq(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reduced_handshake = 1'b0;
	logic array_busy = 1'b0;
	logic wr_en, chip_enable_n, address_valid_strobe_n, burst_hold;
	logic rdy_o, rdy_oe, sync_mode, active_edge_rise, cfg_loaded;
	logic [`ADDR_W-1:0] wr_addr, start_addr, array_addr;
	logic [`DATA_W-1:0] wr_data, array_data, burst_data;
	int err_count = 0;
	int n_compared = 0;
	int k;
	// 125 MHz
	always #4 clk = ~clk;
	// array pattern from address, so a wrong pointer shows as a wrong word
	assign array_data = array_addr[15:0] ^ 16'h5A3C;
	host_model host_model_inst (.clk, .wr_en, .wr_addr, .wr_data, .chip_enable_n, .address_valid_strobe_n,
		.start_addr, .burst_hold);
	flash_burst_config flash_burst_config_inst (.clk, .rst, .reduced_handshake, .wr_en, .wr_addr, .wr_data,
		.array_busy, .chip_enable_n, .address_valid_strobe_n, .start_addr, .burst_hold, .array_addr, .array_data,
		.burst_data, .rdy_o, .rdy_oe, .sync_mode, .active_edge_rise, .cfg_loaded);
	function automatic logic [21:0] step(input logic [21:0] a, input logic [1:0] w);
		case (w)
			2'h1: step = {a[21:3], a[2:0] + 3'h1};
			2'h2: step = {a[21:4], a[3:0] + 4'h1};
			2'h3: step = {a[21:5], a[4:0] + 5'h1};
			default: step = a + 22'h000001;
		endcase
	endfunction : step
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	task automatic report(input string s);
		$display("test %s done, mismatches %0d", s, err_count);
	endtask : report
	task automatic setup(input logic [7:0] v);
		host_model_inst.load(v);
		repeat (2) @(posedge clk);
		#1;
	endtask : setup
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			`check_eq(rdy_o, 1'b0)
		end
	endtask : quiet
	// bounded wait for ready; running out ends the run
	task automatic wait_rdy(input int bound, output int n);
		n = 0;
		while (n < bound) begin
			@(posedge clk);
			#1;
			n++;
			if (rdy_o === 1'b1) return;
		end
		err_count++;
		$display("BAD t=%0t no ready", $time);
		close_out();
	endtask : wait_rdy
	// a stall longer than the buffer makes it fill and refuse before draining
	task automatic burst(input logic [21:0] a, input logic [1:0] w, input int lat, input int nw, input int hold);
		logic [21:0] p;
		p = a;
		host_model_inst.strobe(a, hold > 0);
		quiet(hold);
		if (hold > 0) host_model_inst.release_hold();
		wait_rdy(40, k);
		// k counts edges after the one that samples the strobe, one short of the wait
		if (lat > 0) `check_eq(k + 1, lat)
		for (int i = 0; i < nw; i++) begin
			if (i > 0) begin
				wait_rdy(8, k);
				`check_eq(k, 1)
			end
			`check_eq(burst_data, p[15:0] ^ 16'h5A3C)
			p = step(p, w);
		end
		host_model_inst.end_burst();
	endtask : burst
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`check_eq(cfg_loaded, 1'b0)
		`check_eq(sync_mode, 1'b0)
		`check_eq(rdy_oe, 1'b0)
		`check_eq(active_edge_rise, 1'b1)
		host_model_inst.strobe(22'h000100, 1'b0);
		quiet(12);
		host_model_inst.end_burst();
		host_model_inst.write_cycle(22'h000555, 16'h00AA);
		host_model_inst.write_cycle(22'h0002AA, 16'h0033);
		host_model_inst.write_cycle(22'h005555, 16'h00C0);
		host_model_inst.write_release();
		repeat (2) @(posedge clk);
		#1;
		`check_eq(cfg_loaded, 1'b0)
		report("reset and refusals");
		setup(8'h65);
		`check_eq(cfg_loaded, 1'b1)
		`check_eq(sync_mode, 1'b1)
		`check_eq(rdy_oe, 1'b1)
		for (int c = 0; c < 8; c++) begin
			setup(8'h60 | 8'(c));
			burst(22'h000010, 2'h0, (c > 5) ? 7 : c + 2, 3, 0);
		end
		setup(8'h65);
		burst(22'h00003F, 2'h0, 7, 2, 0);
		@(posedge clk);
		reduced_handshake <= 1'b1;
		setup(8'h62);
		burst(22'h00007E, 2'h0, 6, 2, 0);
		burst(22'h000041, 2'h0, 4, 2, 0);
		@(posedge clk);
		reduced_handshake <= 1'b0;
		report("wait counts");
		for (int w = 1; w < 4; w++) begin
			setup(8'h60 | 8'(w << 3));
			burst(22'h00003D, 2'(w), 2, 12, 0);
		end
		setup(8'h60);
		burst(22'h3FFFFE, 2'h0, 2, 4, 0);
		burst(22'h000100, 2'h0, -1, 24, 30);
		report("wrap and buffer");
		setup(8'h65);
		host_model_inst.strobe(22'h000200, 1'b0);
		host_model_inst.end_burst();
		quiet(12);
		@(posedge clk);
		array_busy <= 1'b1;
		host_model_inst.load(8'hE5);
		array_busy <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`check_eq(sync_mode, 1'b1)
		burst(22'h000010, 2'h0, 7, 1, 0);
		setup(8'h25);
		host_model_inst.strobe(22'h000010, 1'b0);
		wait_rdy(40, k);
		`check_eq(k + 1, 6)
		@(posedge clk);
		#1;
		`check_eq(burst_data, 16'h0010 ^ 16'h5A3C)
		host_model_inst.end_burst();
		setup(8'h20);
		burst(22'h000010, 2'h0, 2, 2, 0);
		setup(8'h45);
		`check_eq(active_edge_rise, 1'b0)
		setup(8'hE5);
		`check_eq(sync_mode, 1'b0)
		`check_eq(rdy_oe, 1'b0)
		host_model_inst.strobe(22'h000010, 1'b0);
		quiet(12);
		host_model_inst.end_burst();
		report("abort, lock, ready and mode");
		close_out();
	end
endmodule : testbench
